//--- core/eewc_pkg.sv
// Package for the edge event wakeup controller: map, layouts, constants
package eewc_pkg;
   localparam int NUM_LINES   = 41;
   localparam int NUM_EXT     = 16;
   localparam int NUM_INT     = NUM_LINES - NUM_EXT;
   localparam int NUM_PINS    = 136;
   localparam int PIN_SEL_W   = 8;
   localparam int NUM_IRQ_CH  = 90;
   localparam int NUM_PRIO    = 16;
   localparam int ADDR_W      = 6;

   typedef logic [NUM_LINES-1:0] eewc_lines_t;
   typedef logic [PIN_SEL_W-1:0] eewc_sel_t;

   // Word byte addresses
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_RISE_EN   = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_FALL_EN   = 6'h0c;
   localparam logic [ADDR_W-1:0] OFF_SW_TRIG   = 6'h10;
   localparam logic [ADDR_W-1:0] OFF_PENDING   = 6'h14;
   localparam logic [ADDR_W-1:0] OFF_HI_BASE   = 6'h20;
   // High halves fill 0x20..0x34, so the pin window sits below them
   localparam logic [ADDR_W-1:0] OFF_PIN_SEL   = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_SEL_DATA  = 6'h1c;
   localparam logic [ADDR_W-1:0] OFF_LINE_LVL  = 6'h38;
   localparam int                HI_BITS       = NUM_LINES - 32;

   localparam eewc_lines_t IRQ_MASK_RST = '0;
   localparam eewc_lines_t EVT_MASK_RST = '0;
   localparam eewc_lines_t EDGE_EN_RST  = '0;
   localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [31:0]       writedata;
      logic [3:0]        byteenable;
   } eewc_bus_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } eewc_bus_rsp_s;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } eewc_bus_e;
endpackage : eewc_pkg

//--- core/eewc_edge_cell.sv
// One line's asynchronous edge catcher with clocked acknowledge
`timescale 1ns/10ps
`default_nettype none
module eewc_edge_cell (
   input  wire logic clk,      // System clock
   input  wire logic rst_n,    // Sync reset, active low
   input  wire logic line_in,  // Raw line level
   input  wire logic rise_en,  // Catch rising edges
   input  wire logic fall_en,  // Catch falling edges
   input  wire logic ack,      // Release the caught edge
   output logic      hit       // Synchronised edge seen, level
);
   logic rise_cap_r;
   logic fall_cap_r;
   logic sync1_r;
   logic sync2_r;
   logic clr_r;

   // Edge-clocked catch so pulses shorter than clk are kept
   always_ff @(posedge line_in or posedge clr_r) begin
      if (clr_r)
         rise_cap_r <= 1'b0;
      else
         rise_cap_r <= rise_en;
   end

   always_ff @(negedge line_in or posedge clr_r) begin
      if (clr_r)
         fall_cap_r <= 1'b0;
      else
         fall_cap_r <= fall_en;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= rise_cap_r | fall_cap_r;
         sync2_r <= sync1_r;
      end
   end

   // Clear held until the catch has visibly dropped
   always_ff @(posedge clk) begin
      if (!rst_n)
         clr_r <= 1'b1;
      else if (ack)
         clr_r <= 1'b1;
      else if (!sync2_r)
         clr_r <= 1'b0;
   end

   assign hit = sync2_r & ~clr_r;
endmodule : eewc_edge_cell
`default_nettype wire

//--- core/eewc_top.sv
// Edge event wakeup controller with Avalon-MM register slave
// What this block does
// - Forty-one edge lines, each raising interrupt, event and Stop wakeup.
// - Each line selects rising, falling or both edges independently.
// - Per-line mask blocks forwarding without touching other lines.
// - Per-line readable pending bit records each trigger on a line whose irq mask bit is set.
// - Pulses shorter than a clock period are still caught.
// - Sixteen external lines each pick one of 136 pins.
// - Remaining lines are driven by on-chip wake-capable peripherals.
// - Downstream controller takes 90 channels, 16 core lines, 16 levels.
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module eewc_top
   import eewc_pkg::*;
(
   input  wire logic                   clk,          // System clock, 20 MHz
   input  wire logic                   rst_n,        // Sync reset, active low
   input  wire eewc_pkg::eewc_bus_req_s avs_req,     // Avalon-MM request
   output var eewc_pkg::eewc_bus_rsp_s avs_rsp,      // Avalon-MM answer
   input  wire logic [NUM_PINS-1:0]    gpio_in,      // Pin levels
   input  wire logic [NUM_INT-1:0]     periph_wake,  // Peripheral wake levels
   output logic [NUM_EXT-1:0]          ext_irq,      // External line irqs
   output logic                        periph_irq,   // Internal lines irq
   output logic                        event_out,    // Event pulse
   output logic                        wakeup,       // Stop mode wake
   output logic                        irq           // Combined level irq
);
   import eewc_pkg::*;

   eewc_lines_t irq_mask_r;
   eewc_lines_t evt_mask_r;
   eewc_lines_t rise_en_r;
   eewc_lines_t fall_en_r;
   eewc_lines_t pending_r;
   eewc_lines_t pending_nxt;
   eewc_lines_t sw_trig;
   eewc_lines_t hit;
   eewc_lines_t hit_d_r;
   eewc_lines_t new_edge;
   eewc_lines_t ack;
   eewc_lines_t line_lvl;
   eewc_lines_t clr_mask;
   eewc_lines_t fwd;
   eewc_lines_t lvl_s1_r;
   eewc_lines_t lvl_s2_r;
   eewc_sel_t   pin_sel_r [NUM_EXT];
   logic [3:0]  sel_idx_r;
   logic [31:0] rdata_r;
   logic        evt_r;
   logic        wake_r;
   logic [NUM_EXT-1:0] ext_irq_r;
   logic        periph_irq_r;
   logic        irq_r;
   eewc_bus_e   bus_state_r;
   logic        wr_hit;
   logic        rd_hit;
   logic [31:0] wd;

   assign wd     = avs_req.writedata;
   assign rd_hit = avs_req.read & (bus_state_r == BUS_IDLE);
   assign wr_hit = avs_req.write & (bus_state_r == BUS_IDLE);

   // Source routing per line; internal lines come straight from peripherals
   genvar g;
   generate
      for (g = 0; g < NUM_LINES; g++) begin : g_line
         if (g < NUM_EXT) begin : g_ext
            always_comb begin
               if (pin_sel_r[g] < NUM_PINS[PIN_SEL_W-1:0])
                  line_lvl[g] = gpio_in[pin_sel_r[g]];
               else
                  line_lvl[g] = 1'b0;
            end
         end else begin : g_int
            assign line_lvl[g] = periph_wake[g-NUM_EXT];
         end

         eewc_edge_cell u_cell (
            .clk     (clk),
            .rst_n   (rst_n),
            .line_in (line_lvl[g]),
            .rise_en (rise_en_r[g]),
            .fall_en (fall_en_r[g]),
            .ack     (ack[g]),
            .hit     (hit[g])
         );
      end
   endgenerate

   // Edge is consumed the cycle after it appears, one pulse per catch
   always_ff @(posedge clk) begin
      if (!rst_n)
         hit_d_r <= '0;
      else
         hit_d_r <= hit;
   end
   assign new_edge = hit & ~hit_d_r;
   assign ack      = hit_d_r;

   // Software trigger bits act like a detected edge for pending and event, but never raise wakeup
   always_comb begin
      sw_trig = '0;
      if (wr_hit && avs_req.address == OFF_SW_TRIG)
         sw_trig[31:0] = wd;
      else if (wr_hit && avs_req.address == (OFF_SW_TRIG + OFF_HI_BASE))
         sw_trig[NUM_LINES-1:32] = wd[HI_BITS-1:0];
   end

   always_comb begin
      clr_mask = '0;
      if (wr_hit && avs_req.address == OFF_PENDING)
         clr_mask[31:0] = wd;
      else if (wr_hit && avs_req.address == (OFF_PENDING + OFF_HI_BASE))
         clr_mask[NUM_LINES-1:32] = wd[HI_BITS-1:0];
   end

   // Pending: set beats clear so a coincident edge is never lost
   always_comb begin
      pending_nxt = (pending_r & ~clr_mask)
                  | ((new_edge | sw_trig) & irq_mask_r);
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         pending_r <= '0;
      else
         pending_r <= pending_nxt;
   end

   // Masked again on the way out, so a line masked after it fired goes quiet
   assign fwd = pending_nxt & irq_mask_r;

   // Level readback only; the edge path cannot be synchronised or short pulses are lost
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lvl_s1_r <= '0;
         lvl_s2_r <= '0;
      end else begin
         lvl_s1_r <= line_lvl;
         lvl_s2_r <= lvl_s1_r;
      end
   end

   // Configuration writes, low word and high word per register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_mask_r <= IRQ_MASK_RST;
         evt_mask_r <= EVT_MASK_RST;
         rise_en_r  <= EDGE_EN_RST;
         fall_en_r  <= EDGE_EN_RST;
      end else if (wr_hit) begin
         if (avs_req.address == OFF_IRQ_MASK)
            irq_mask_r[31:0] <= wd;
         else if (avs_req.address == OFF_IRQ_MASK + OFF_HI_BASE)
            irq_mask_r[NUM_LINES-1:32] <= wd[HI_BITS-1:0];
         else if (avs_req.address == OFF_EVT_MASK)
            evt_mask_r[31:0] <= wd;
         else if (avs_req.address == OFF_EVT_MASK + OFF_HI_BASE)
            evt_mask_r[NUM_LINES-1:32] <= wd[HI_BITS-1:0];
         else if (avs_req.address == OFF_RISE_EN)
            rise_en_r[31:0] <= wd;
         else if (avs_req.address == OFF_RISE_EN + OFF_HI_BASE)
            rise_en_r[NUM_LINES-1:32] <= wd[HI_BITS-1:0];
         else if (avs_req.address == OFF_FALL_EN)
            fall_en_r[31:0] <= wd;
         else if (avs_req.address == OFF_FALL_EN + OFF_HI_BASE)
            fall_en_r[NUM_LINES-1:32] <= wd[HI_BITS-1:0];
      end
   end

   // Pin selection through an index and data window
   always_ff @(posedge clk) begin
      if (!rst_n)
         sel_idx_r <= '0;
      else if (wr_hit && avs_req.address == OFF_PIN_SEL)
         sel_idx_r <= wd[3:0];
   end

   generate
      for (g = 0; g < NUM_EXT; g++) begin : g_sel
         always_ff @(posedge clk) begin
            if (!rst_n)
               pin_sel_r[g] <= eewc_sel_t'(g);
            else if (wr_hit && avs_req.address == OFF_SEL_DATA && sel_idx_r == 4'(g))
               pin_sel_r[g] <= wd[PIN_SEL_W-1:0];
         end
      end
   endgenerate

   // Outputs toward the nested_irq_ctrl and power control
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext_irq_r    <= '0;
         periph_irq_r <= 1'b0;
         irq_r        <= 1'b0;
         evt_r        <= 1'b0;
         wake_r       <= 1'b0;
      end else begin
         ext_irq_r    <= fwd[NUM_EXT-1:0];
         periph_irq_r <= |fwd[NUM_LINES-1:NUM_EXT];
         irq_r        <= |fwd;
         evt_r        <= |((new_edge | sw_trig) & evt_mask_r);
         wake_r       <= |(hit & (irq_mask_r | evt_mask_r));
      end
   end

   assign ext_irq    = ext_irq_r;
   assign periph_irq = periph_irq_r;
   assign irq        = irq_r;
   assign event_out  = evt_r;
   assign wakeup     = wake_r;

   // One wait cycle per access, answer on the second edge
   always_ff @(posedge clk) begin
      if (!rst_n)
         bus_state_r <= BUS_IDLE;
      else begin
         case (bus_state_r)
            BUS_IDLE: begin
               if (avs_req.read || avs_req.write)
                  bus_state_r <= BUS_ACK;
            end
            default: bus_state_r <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         rdata_r <= '0;
      else if (rd_hit) begin
         if (avs_req.address == OFF_IRQ_MASK)
            rdata_r <= irq_mask_r[31:0];
         else if (avs_req.address == OFF_IRQ_MASK + OFF_HI_BASE)
            rdata_r <= 32'(irq_mask_r[NUM_LINES-1:32]);
         else if (avs_req.address == OFF_EVT_MASK)
            rdata_r <= evt_mask_r[31:0];
         else if (avs_req.address == OFF_EVT_MASK + OFF_HI_BASE)
            rdata_r <= 32'(evt_mask_r[NUM_LINES-1:32]);
         else if (avs_req.address == OFF_RISE_EN)
            rdata_r <= rise_en_r[31:0];
         else if (avs_req.address == OFF_RISE_EN + OFF_HI_BASE)
            rdata_r <= 32'(rise_en_r[NUM_LINES-1:32]);
         else if (avs_req.address == OFF_FALL_EN)
            rdata_r <= fall_en_r[31:0];
         else if (avs_req.address == OFF_FALL_EN + OFF_HI_BASE)
            rdata_r <= 32'(fall_en_r[NUM_LINES-1:32]);
         else if (avs_req.address == OFF_PENDING)
            rdata_r <= pending_r[31:0];
         else if (avs_req.address == OFF_PENDING + OFF_HI_BASE)
            rdata_r <= 32'(pending_r[NUM_LINES-1:32]);
         else if (avs_req.address == OFF_PIN_SEL)
            rdata_r <= 32'(sel_idx_r);
         else if (avs_req.address == OFF_SEL_DATA)
            rdata_r <= 32'(pin_sel_r[sel_idx_r]);
         else if (avs_req.address == OFF_LINE_LVL)
            rdata_r <= lvl_s2_r[31:0];
         else
            rdata_r <= UNMAPPED_RD;
      end
   end

   always_comb begin
      avs_rsp.readdata    = rdata_r;
      avs_rsp.waitrequest = (bus_state_r == BUS_IDLE);
   end
endmodule : eewc_top
`default_nettype wire

//--- tb/eewc_top_sva.sv
// Port checker for the edge event wakeup controller
`timescale 1ns/10ps
`default_nettype none
module eewc_top_sva
   import eewc_pkg::*;
(
   input wire logic                          clk,        // System clock
   input wire logic                          rst_n,      // Sync reset
   input wire eewc_pkg::eewc_bus_req_s       avs_req,    // Bus request
   input wire eewc_pkg::eewc_bus_rsp_s       avs_rsp,    // Bus answer
   input wire logic [eewc_pkg::NUM_EXT-1:0]  ext_irq,    // External irqs
   input wire logic                          periph_irq, // Internal irq
   input wire logic                          irq         // Combined irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   ack_one_cycle_a: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
      else $error("ack held past one cycle");
   req_acked_a: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
      |=> !avs_rsp.waitrequest)
      else $error("request not acked next cycle");
   irq_any_a: assert property (irq == (|ext_irq || periph_irq))
      else $error("irq not the sum of line irqs");
   rst_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !irq && ext_irq == '0 && avs_rsp.waitrequest)
      else $error("outputs active after reset");
   irq_drop_a: assert property ($fell(irq) |-> $past(avs_req.write))
      else $error("irq dropped without a write");
   line_drop_a: assert property (|($past(ext_irq) & ~ext_irq) |-> $past(avs_req.write))
      else $error("line irq dropped without a write");
   unmapped_zero_a: assert property (avs_req.read && !avs_rsp.waitrequest && avs_req.address == 6'h3c
      |-> avs_rsp.readdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property ($changed(avs_rsp.readdata) |-> $past(avs_req.read))
      else $error("read data moved without a read");
endmodule : eewc_top_sva

bind eewc_top eewc_top_sva u_sva (.clk(clk), .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp),
   .ext_irq(ext_irq), .periph_irq(periph_irq), .irq(irq));
`default_nettype wire

//--- tb/eewc_nirq_model.sv
// Behavioural model of the downstream nested interrupt controller
`timescale 1ns/10ps
`default_nettype none
module eewc_nirq_model
   import eewc_pkg::*;
(
   input wire logic                            clk,        // System clock
   input wire logic                            rst_n,      // Sync reset
   input wire logic [eewc_pkg::NUM_EXT-1:0]    ext_irq,    // External channels
   input wire logic                            periph_irq, // Shared channel
   input wire logic                            event_out,  // Event pulses
   output var logic [eewc_pkg::NUM_IRQ_CH-1:0] taken,      // Channels seen
   output var int                              n_events    // Events seen
);
   // Sticky so a short level is still visible to the bench
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         taken    <= '0;
         n_events <= 0;
      end else begin
         taken <= taken | {{(NUM_IRQ_CH-NUM_EXT-1){1'b0}}, periph_irq, ext_irq};
         if (event_out) begin
            n_events <= n_events + 1;
         end
      end
   end
endmodule : eewc_nirq_model
`default_nettype wire

//--- tb/edge_event_wakeup_controller_tb.sv
// Self-checking bench for the edge event wakeup controller
`timescale 1ns/10ps
`default_nettype none
module edge_event_wakeup_controller_tb;
   import eewc_pkg::*;
   typedef struct packed {logic [5:0] ln; logic ri; logic fa; logic up; logic en; logic ex;} eewc_row_s;
   localparam eewc_row_s ROWS [8] = '{'{0, 1, 0, 1, 1, 1}, '{1, 1, 0, 0, 1, 0}, '{2, 0, 1, 0, 1, 1},
      '{3, 0, 1, 1, 1, 0}, '{4, 1, 1, 1, 1, 1}, '{5, 1, 1, 0, 1, 1}, '{6, 1, 0, 1, 0, 0}, '{15, 1, 0, 1, 1, 1}};
   logic                  clk         = 1'b0;
   logic                  rst_n       = 1'b0;
   eewc_bus_req_s         avs_req     = '0;
   eewc_bus_rsp_s         avs_rsp;
   logic [NUM_PINS-1:0]   gpio_in     = '0;
   logic [NUM_INT-1:0]    periph_wake = '0;
   logic [NUM_EXT-1:0]    ext_irq;
   logic                  periph_irq;
   logic                  event_out;
   logic                  irq;
   logic                  wakeup;
   logic [NUM_IRQ_CH-1:0] taken;
   int                    n_events;
   int                    mismatches  = 0;
   int                    tests_run   = 0;
   int                    n_wake      = 0;
   int                    w0          = 0;
   logic [31:0]           q;
   eewc_row_s             r;

   always #25 clk = ~clk;

   eewc_top u_dut (.clk(clk), .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp), .gpio_in(gpio_in),
      .periph_wake(periph_wake), .ext_irq(ext_irq), .periph_irq(periph_irq), .event_out(event_out),
      .wakeup(wakeup), .irq(irq));
   eewc_nirq_model u_nic (.clk(clk), .rst_n(rst_n), .ext_irq(ext_irq), .periph_irq(periph_irq),
      .event_out(event_out), .taken(taken), .n_events(n_events));

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   // Wake level lasts only while an edge is synchronised, so count it
   always @(posedge clk) begin
      if (wakeup === 1'b1)
         n_wake <= n_wake + 1;
   end

   // Request held until waitrequest is seen low at a rising edge; data taken there
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_req <= '{a, !wr, wr, d, 4'hf};
      do @(posedge clk); while (avs_rsp.waitrequest !== 1'b0);
      q = avs_rsp.readdata;
      avs_req <= '0;
   endtask : bus

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, OFF_IRQ_MASK, 0);
      chk("irq mask reset", 32'h0, q);
      bus(0, OFF_RISE_EN, 0);
      chk("rise enable reset", 32'h0, q);
      foreach (ROWS[i]) begin
         r = ROWS[i];
         gpio_in[r.ln] <= !r.up;
         bus(1, OFF_IRQ_MASK, 32'(r.en) << r.ln);
         bus(1, OFF_RISE_EN, 32'(r.ri) << r.ln);
         bus(1, OFF_FALL_EN, 32'(r.fa) << r.ln);
         gpio_in[r.ln] <= r.up;
         repeat (8) @(posedge clk);
         bus(0, OFF_PENDING, 0);
         chk("pending", 32'(r.ex) << r.ln, q);
         chk("ext_irq", 32'(r.ex), 32'(ext_irq[r.ln]));
         bus(1, OFF_PENDING, 32'hffff_ffff);
         bus(1, OFF_RISE_EN, 0);
         bus(1, OFF_FALL_EN, 0);
         gpio_in[r.ln] <= 1'b0;
      end
      bus(1, OFF_IRQ_MASK, 32'h81);
      bus(1, OFF_SW_TRIG, 32'h80);
      bus(1, OFF_PENDING, 0);
      bus(0, OFF_PENDING, 0);
      chk("pending kept", 32'h80, q);
      chk("channel 7", 1, 32'(taken[7]));
      bus(1, OFF_PENDING, 32'h80);
      bus(0, OFF_PENDING, 0);
      chk("pending cleared", 0, q);
      repeat (3) @(posedge clk);
      chk("irq", 0, 32'(irq));
      bus(1, OFF_RISE_EN, 1);
      // Pulse sits wholly between two clock edges
      #10 gpio_in[0] = 1'b1;
      #10 gpio_in[0] = 1'b0;
      repeat (8) @(posedge clk);
      bus(0, OFF_PENDING, 0);
      chk("short pulse", 1, q);
      bus(1, OFF_PIN_SEL, 3);
      bus(1, OFF_SEL_DATA, 100);
      bus(0, OFF_SEL_DATA, 0);
      chk("pin select", 100, q);
      bus(1, OFF_IRQ_MASK, 8);
      bus(1, OFF_RISE_EN, 8);
      bus(1, OFF_PENDING, 1);
      gpio_in[3] <= 1'b1;
      repeat (8) @(posedge clk);
      chk("old pin", 0, 32'(ext_irq[3]));
      gpio_in[100] <= 1'b1;
      repeat (8) @(posedge clk);
      chk("new pin", 1, 32'(ext_irq[3]));
      chk("irq raised", 1, 32'(irq));
      bus(0, OFF_LINE_LVL, 0);
      chk("line level", 32'h8, q);
      bus(0, 6'h3c, 0);
      chk("unmapped", 0, q);
      bus(1, OFF_HI_BASE + OFF_IRQ_MASK, 1);
      bus(1, OFF_HI_BASE + OFF_EVT_MASK, 1);
      bus(1, OFF_HI_BASE + OFF_RISE_EN, 1);
      w0 = n_wake;
      // Line 32 is fed by peripheral input 16
      periph_wake[16] <= 1'b1;
      repeat (8) @(posedge clk);
      chk("periph_irq", 1, 32'(periph_irq));
      chk("events", 1, n_events);
      chk("channel 16", 1, 32'(taken[16]));
      chk("wakeup", 1, 32'(n_wake > w0));
      close_out();
   end
endmodule : edge_event_wakeup_controller_tb
`default_nettype wire
